/* protect_cfg.svh */
// Offsets, bit positions and reset values of the protection register pair
`ifndef PROTECT_CFG_SVH
`define PROTECT_CFG_SVH

`define PROT_CTL_ADDR 8'hC3
`define PROT_STS_ADDR 8'hC4
`define PROT_CTL_RESET 8'h00
`define PROT_STS_RESET 8'h00

`define CTL_PROT_RESET_BIT 7
`define CTL_LIST_OK_BIT 5
`define CTL_RX_KEY_OK_BIT 4
`define CTL_CIPHER_OFF_BIT 3
`define CTL_CIPHER_ON_BIT 2
`define CTL_AUTH_STOP_BIT 1
`define CTL_AUTH_START_BIT 0

`define STS_SIDE_ERR_BIT 7
`define STS_REMOTE_IRQ_BIT 6
`define STS_REMOTE_LOCK_BIT 5
`define STS_LIST_READY_BIT 2
`define STS_RX_KEY_READY_BIT 1
`define STS_AUTH_DONE_BIT 0

`define CIPHER_POLICY_ALWAYS 2'h3

`endif

/* protect_pkg.sv */
// Types shared by the protection control and status logic
`default_nettype none
package protect_pkg;
  typedef enum logic [1:0] {
    VIDEO_PLAIN,
    VIDEO_ENCRYPTED,
    VIDEO_BLUE_SCREEN
  } video_mode_t;
endpackage : protect_pkg
`default_nettype wire

/* content_protect_ctl_status.sv */
// Protection control and status register pair with its request and flag logic
// Summary of operation
// - Writing one to control bit 7 resets the transmitter, stops authentication; self-clears.
// - Host approves repeater key list via bit 5; authentication completes; bit self-clears.
// - Host approves receiver key via bit 4; writing zero does nothing.
// - Receiver-key-approved bit clears when receiver-key-ready flag is asserted.
// - Writing one to bit 3 sends video unencrypted except under always-encrypt policy, keeps authentication; self-clears.
// - With bit 2 set: encrypted video if authenticated, else blue screen.
// - With encryption-on bit clear, video is sent unencrypted.
// - Under always-encrypt policy the encryption-on bit is read-only and reads one.
// - Writing one to bit 1 disables authentication; bit self-clears.
// - Writing one to bit 0 enables or restarts authentication; zero does nothing.
// - Reading bit 0 returns current authentication-enabled state.
// - Status bit 7 sets on side-channel error, clears when status is read.
// - Status bit 6 shows remote interrupt level, active low.
// - Status bit 5 shows remote receiver lock to serial data.
// - Receiver-key-ready flag sets after key read; clears when host approves key.
// - Key-list-ready flag sets when list available; clears when host approves list.
// - Authentication-done flag clears on lost authentication or restart.
`timescale 1ns/1ns
`default_nettype none
`include "protect_cfg.svh"

module content_protect_ctl_status
  import protect_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [1:0] cipher_policy_in,
  input wire logic side_channel_error_in,
  input wire logic remote_irq_input_in,
  input wire logic remote_lock_seen_in,
  input wire logic receiver_key_ready_in,
  input wire logic key_list_ready_in,
  input wire logic auth_pass_in,
  input wire logic auth_lost_in,
  output logic protection_reset_out,
  output logic key_list_approved_out,
  output logic receiver_key_approved_out,
  output logic cipher_off_pulse_out,
  output logic auth_stop_out,
  output logic auth_start_out,
  output logic auth_enable_out,
  output video_mode_t video_mode_out
);

  // ------------------------------------------------------------
  // Link-side status synchronisers
  // ------------------------------------------------------------
  logic [1:0] link_meta_q;
  logic [1:0] link_sync_q;

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      link_meta_q <= 2'h0;
      link_sync_q <= 2'h0;
    end
    else
    begin
      link_meta_q <= {remote_irq_input_in, remote_lock_seen_in};
      link_sync_q <= link_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  wire ctl_wr = reg_wr_in && (reg_addr_in == `PROT_CTL_ADDR);
  wire sts_rd = reg_rd_in && (reg_addr_in == `PROT_STS_ADDR);
  wire ctl_rd = reg_rd_in && (reg_addr_in == `PROT_CTL_ADDR);
  wire wr_reset = ctl_wr && reg_wdata_in[`CTL_PROT_RESET_BIT];
  wire wr_list_ok = ctl_wr && reg_wdata_in[`CTL_LIST_OK_BIT];
  wire wr_key_ok = ctl_wr && reg_wdata_in[`CTL_RX_KEY_OK_BIT];
  wire wr_cipher_off = ctl_wr && reg_wdata_in[`CTL_CIPHER_OFF_BIT];
  wire wr_stop = ctl_wr && reg_wdata_in[`CTL_AUTH_STOP_BIT];
  wire wr_start = ctl_wr && reg_wdata_in[`CTL_AUTH_START_BIT];
  wire policy_always = (cipher_policy_in == `CIPHER_POLICY_ALWAYS);

  // ------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------
  logic auth_en_q;
  logic auth_en_d;
  logic cipher_on_q;
  logic cipher_on_d;
  logic key_ok_q;
  logic key_ok_d;
  logic key_ready_q;
  logic side_err_q;
  logic key_rdy_flag_q;
  logic list_rdy_flag_q;
  logic auth_done_q;

  // Stop and reset override a start in the same write
  assign auth_en_d = (wr_reset || wr_stop) ? 1'b0 : (wr_start ? 1'b1 : auth_en_q);
  // Cipher-off turns encryption off but leaves authentication untouched
  assign cipher_on_d = ctl_wr && !wr_cipher_off ?
                       reg_wdata_in[`CTL_CIPHER_ON_BIT] :
                       (wr_cipher_off ? 1'b0 : cipher_on_q);
  wire cipher_on_eff = cipher_on_q || policy_always;
  wire key_ready_rise = receiver_key_ready_in && !key_ready_q;
  // Rising ready means a fresh key, so any stale approval is dropped
  assign key_ok_d = key_ready_rise ? 1'b0 : (wr_key_ok ? 1'b1 : key_ok_q);

  wire [7:0] ctl_view = {2'h0, 1'b0, key_ok_q, 1'b0, cipher_on_eff, 1'b0, auth_en_q};
  wire [7:0] sts_view = {side_err_q, link_sync_q[1], link_sync_q[0], 2'h0,
                         list_rdy_flag_q, key_rdy_flag_q, auth_done_q};
  wire [7:0] rd_mux = ctl_rd ? ctl_view : (sts_rd ? sts_view : 8'h00);
  wire video_mode_t mode_d = !cipher_on_eff ? VIDEO_PLAIN :
                             (auth_done_q ? VIDEO_ENCRYPTED : VIDEO_BLUE_SCREEN);

  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      auth_en_q <= 1'b0;
      cipher_on_q <= 1'b0;
      key_ok_q <= 1'b0;
      key_ready_q <= 1'b0;
    end
    else
    begin
      auth_en_q <= auth_en_d;
      cipher_on_q <= cipher_on_d;
      key_ok_q <= key_ok_d;
      key_ready_q <= receiver_key_ready_in;
    end
  end

  // ------------------------------------------------------------
  // Status flags: a new event wins over a same-cycle clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      side_err_q <= 1'b0;
      key_rdy_flag_q <= 1'b0;
      list_rdy_flag_q <= 1'b0;
      auth_done_q <= 1'b0;
    end
    else
    begin
      side_err_q <= side_channel_error_in || (side_err_q && !sts_rd);
      key_rdy_flag_q <= key_ready_rise || (key_rdy_flag_q && !wr_key_ok && !wr_reset);
      list_rdy_flag_q <= key_list_ready_in ||
                         (list_rdy_flag_q && !wr_list_ok && !wr_reset);
      auth_done_q <= auth_pass_in ||
                     (auth_done_q && !auth_lost_in && !wr_start && !wr_stop && !wr_reset);
    end
  end

  // ------------------------------------------------------------
  // Registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_rdata_out <= `PROT_STS_RESET;
      protection_reset_out <= 1'b0;
      key_list_approved_out <= 1'b0;
      receiver_key_approved_out <= 1'b0;
      cipher_off_pulse_out <= 1'b0;
      auth_stop_out <= 1'b0;
      auth_start_out <= 1'b0;
      auth_enable_out <= 1'b0;
      video_mode_out <= VIDEO_PLAIN;
    end
    else
    begin
      if (reg_rd_in)
        reg_rdata_out <= rd_mux;
      protection_reset_out <= wr_reset;
      key_list_approved_out <= wr_list_ok;
      receiver_key_approved_out <= key_ok_d;
      cipher_off_pulse_out <= wr_cipher_off;
      auth_stop_out <= wr_stop;
      auth_start_out <= wr_start && !wr_stop && !wr_reset;
      auth_enable_out <= auth_en_d;
      video_mode_out <= mode_d;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_reset_pulse;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_reset |=> protection_reset_out ##1 (!protection_reset_out || $past(wr_reset));
  endproperty
  a_reset_pulse: assert property (p_reset_pulse) else $error("reset pulse wrong");

  property p_reset_stops_auth;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_reset |=> !auth_enable_out && !auth_en_q;
  endproperty
  a_reset_stops_auth: assert property (p_reset_stops_auth) else $error("reset kept auth");

  property p_list_clears_flag;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (wr_list_ok && !key_list_ready_in) |=> !list_rdy_flag_q && key_list_approved_out;
  endproperty
  a_list_clears_flag: assert property (p_list_clears_flag) else $error("list flag held");

  property p_key_ok_drop;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    key_ready_rise |=> !receiver_key_approved_out && !key_ok_q;
  endproperty
  a_key_ok_drop: assert property (p_key_ok_drop) else $error("key approval held");

  property p_stop;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    wr_stop |=> (auth_stop_out && !auth_enable_out) ##1 (!auth_stop_out || $past(wr_stop));
  endproperty
  a_stop: assert property (p_stop) else $error("stop wrong");

  property p_start;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (wr_start && !wr_stop && !wr_reset) |=> auth_enable_out && auth_start_out &&
      (!auth_done_q || $past(auth_pass_in));
  endproperty
  a_start: assert property (p_start) else $error("start wrong");

  property p_read_enable;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    ctl_rd |=> reg_rdata_out[`CTL_AUTH_START_BIT] == $past(auth_en_q)
      && reg_rdata_out[`CTL_AUTH_STOP_BIT] == 1'b0;
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable readback wrong");

  property p_always_on;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (ctl_rd && policy_always) |=> reg_rdata_out[`CTL_CIPHER_ON_BIT];
  endproperty
  a_always_on: assert property (p_always_on) else $error("always policy read zero");

  property p_err_clear;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (sts_rd && side_err_q && !side_channel_error_in) |=>
      reg_rdata_out[`STS_SIDE_ERR_BIT] && !side_err_q;
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flag not cleared");

  property p_video;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    !cipher_on_eff ##1 !cipher_on_eff [*2] |-> video_mode_out == VIDEO_PLAIN;
  endproperty
  a_video: assert property (p_video) else $error("plain video expected");

  property p_blue;
    @(posedge clk_sys_in) disable iff (!reset_n_in)
    (cipher_on_eff && !auth_done_q) |=> video_mode_out == VIDEO_BLUE_SCREEN;
  endproperty
  a_blue: assert property (p_blue) else $error("blue screen expected");

endmodule : content_protect_ctl_status
`default_nettype wire

/* host_model.sv */
// Host controller model for the protection register pair
`timescale 1ns/1ns
`default_nettype none
`include "protect_cfg.svh"
module host_model
(
  input wire logic clk_sys_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in
);
  initial
  begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_wdata_out = 8'h00;
    reg_rd_out = 1'b0;
  end
  // Data inverted after release so a stale byte never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_out <= 1'b0;
    #1;
    d = reg_rdata_in;
  endtask : rd
  // Approval only once the matching ready flag is seen
  task automatic approve(input int unsigned flag_bit, input logic [7:0] ctl);
    logic [7:0] s;
    rd(`PROT_STS_ADDR, s);
    if (s[flag_bit] === 1'b1) wr(`PROT_CTL_ADDR, ctl);
  endtask : approve
endmodule : host_model
`default_nettype wire

/* content_protect_ctl_status_tb.sv */
// Self-checking bench for the protection control and status pair
`timescale 1ns/1ns
`default_nettype none
`include "protect_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module content_protect_ctl_status_tb
  import protect_pkg::*;
;
  logic clk, rst_n, wr, rd, irq_n, lock, key_rdy, rst_p, list_p, rxk, c_off, stop, start, en;
  logic [1:0] policy, r;
  logic [3:0] evt;
  logic [7:0] addr, wdata, rdata, s;
  video_mode_t vmode;
  int n_mismatch = 0;
  int n_tests = 0;
  host_model h (.clk_sys_in(clk), .reg_addr_out(addr), .reg_wr_out(wr), .reg_wdata_out(wdata),
    .reg_rd_out(rd), .reg_rdata_in(rdata));
  content_protect_ctl_status dut (.clk_sys_in(clk), .reset_n_in(rst_n), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .cipher_policy_in(policy), .side_channel_error_in(evt[0]), .remote_irq_input_in(irq_n),
    .remote_lock_seen_in(lock), .receiver_key_ready_in(key_rdy), .key_list_ready_in(evt[3]),
    .auth_pass_in(evt[1]), .auth_lost_in(evt[2]), .protection_reset_out(rst_p),
    .key_list_approved_out(list_p), .receiver_key_approved_out(rxk),
    .cipher_off_pulse_out(c_off), .auth_stop_out(stop), .auth_start_out(start),
    .auth_enable_out(en), .video_mode_out(vmode));
  function automatic logic [7:0] ctl_exp(input logic ok, input logic ciph, input logic on);
    return {3'b000, ok, 1'b0, ciph, 1'b0, on};
  endfunction : ctl_exp
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  // Event inputs held one cycle, then time for flags and video mode to follow
  task automatic ev(input logic [3:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 4'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : ev
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, lock, key_rdy, policy, evt, irq_n} = 10'h001;
    void'($urandom(32'h5F6E));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    h.rd(`PROT_CTL_ADDR, s); `CHK("ctl reset", `PROT_CTL_RESET, s)
    h.rd(`PROT_STS_ADDR, s); `CHK("sts reset", 8'h40, s)
    h.wr(`PROT_CTL_ADDR, 8'h01); `CHK("start", 2'b11, {start, en})
    @(posedge clk); #1; `CHK("start pulse", 1'b0, start)
    h.wr(`PROT_CTL_ADDR, 8'h00); h.rd(`PROT_CTL_ADDR, s); `CHK("ctl on", 8'h01, s)
    h.wr(`PROT_CTL_ADDR, 8'h02); `CHK("stop", 2'b10, {stop, en})
    h.wr(`PROT_CTL_ADDR, 8'h01); h.wr(`PROT_CTL_ADDR, 8'h80); `CHK("prst", 2'b10, {rst_p, en})
    h.rd(`PROT_CTL_ADDR, s); `CHK("self clear", 8'h00, s)
    h.wr(`PROT_CTL_ADDR, 8'h04); repeat (2) @(posedge clk); #1;
    `CHK("blue", VIDEO_BLUE_SCREEN, vmode)
    ev(4'h2); `CHK("encrypted", VIDEO_ENCRYPTED, vmode)
    h.wr(`PROT_CTL_ADDR, 8'h08); `CHK("cipher off", 1'b1, c_off)
    repeat (2) @(posedge clk); #1; `CHK("plain", VIDEO_PLAIN, vmode)
    h.rd(`PROT_STS_ADDR, s); `CHK("auth kept", 1'b1, s[0])
    h.wr(`PROT_CTL_ADDR, 8'h01); h.rd(`PROT_STS_ADDR, s); `CHK("restart", 1'b0, s[0])
    ev(4'h2); h.rd(`PROT_STS_ADDR, s); `CHK("auth set", 1'b1, s[0])
    ev(4'h4); h.rd(`PROT_STS_ADDR, s); `CHK("lost", 1'b0, s[0])
    @(posedge clk); policy <= `CIPHER_POLICY_ALWAYS;
    h.wr(`PROT_CTL_ADDR, 8'h00); h.rd(`PROT_CTL_ADDR, s);
    `CHK("always", ctl_exp(1'b0, 1'b1, 1'b1), s)
    @(posedge clk); policy <= 2'h0;
    h.wr(`PROT_CTL_ADDR, 8'h10); `CHK("key ok", 1'b1, rxk)
    @(posedge clk); key_rdy <= 1'b1;
    repeat (3) @(posedge clk); #1; `CHK("key ok clr", 1'b0, rxk)
    h.rd(`PROT_STS_ADDR, s); `CHK("key ready", 1'b1, s[1])
    h.approve(1, 8'h10); `CHK("key approve", 1'b1, rxk)
    h.wr(`PROT_CTL_ADDR, 8'h00); `CHK("key zero", 1'b1, rxk)
    h.rd(`PROT_STS_ADDR, s); `CHK("key ready clr", 1'b0, s[1])
    ev(4'h8); h.approve(2, 8'h20); `CHK("list ok", 1'b1, list_p)
    h.rd(`PROT_STS_ADDR, s); `CHK("list clr", 1'b0, s[2])
    ev(4'h1); h.rd(`PROT_STS_ADDR, s); `CHK("err set", 1'b1, s[7])
    h.rd(`PROT_STS_ADDR, s); `CHK("err read clr", 1'b0, s[7])
    repeat (8)
    begin
      r = 2'($urandom);
      @(posedge clk); {irq_n, lock} <= r;
      h.wr(8'($urandom_range(8'hBF)), 8'($urandom)); h.wr(`PROT_STS_ADDR, 8'($urandom));
      h.rd(`PROT_STS_ADDR, s); `CHK("remote", r, s[6:5])
      h.rd(`PROT_CTL_ADDR, s); `CHK("ctl kept", ctl_exp(1'b1, 1'b0, 1'b1), s)
      h.rd(8'($urandom_range(8'hBF)), s); `CHK("unmapped", 8'h00, s)
    end
    finish_test();
  end
endmodule : content_protect_ctl_status_tb
`default_nettype wire
